// File: design/column_mem_pkg.sv
// Purpose: shared constants for the steering column memory controller
// Assumes: 40 MHz clock, 32-bit AHB-Lite register slave
// Notes: offsets are byte addresses of aligned words
package column_mem_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 40000000;
  localparam int DISCRIM_MS = 50;
  localparam int DISCRIM_CYC = CLK_HZ / 1000 * DISCRIM_MS;
  localparam int STAGGER_MS = 100;
  localparam int STAGGER_CYC = CLK_HZ / 1000 * STAGGER_MS;
  localparam int SENSE_MS = 1000;
  localparam int SENSE_CYC = CLK_HZ / 1000 * SENSE_MS;
  localparam int SPEED_HOLD_MS = 2000;
  localparam int SPEED_HOLD_CYC = CLK_HZ / 1000 * SPEED_HOLD_MS;
  localparam int BEEP_MS = 100;
  localparam int BEEP_CYC = CLK_HZ / 1000 * BEEP_MS;
  localparam int MIN_PULSES = 4;
  localparam logic [7:0] SPEED_LIMIT_KMH = 8'h03;
  // ==========================================================
  // register map
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0C;
  localparam logic [7:0] SLOT0_OFS = 8'h10;
  localparam logic [7:0] SLOT1_OFS = 8'h14;
  localparam logic [7:0] POS_OFS = 8'h18;
  // command register bits (write one-shot)
  localparam int CMD_MEMSW = 0;
  localparam int CMD_POS0 = 1;
  localparam int CMD_POS1 = 2;
  // interrupt bits
  localparam int IRQ_REG_DONE = 0;
  localparam int IRQ_REPLAY_DONE = 1;
  localparam int IRQ_SENSOR_ERR = 2;
  localparam int IRQ_ABORT = 3;
  localparam int IRQ_W = 4;
  // beep counts
  localparam logic [3:0] BEEPS_PERMIT = 4'h1;
  localparam logic [3:0] BEEPS_REG = 4'h2;
  localparam logic [3:0] BEEPS_REPLAY = 4'h1;
  localparam logic [3:0] BEEPS_ERROR = 4'hA;
  // ==========================================================
  // controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PERMIT = 2'b01,
    ST_REPLAY = 2'b10
  } mode_e;
endpackage : column_mem_pkg

// File: design/steering_column_memory_ctrl.sv
// Purpose: tilt and telescope column memory controller with AHB-Lite registers
// Assumes: all inputs synchronous to ref_clk_in; switches active high
// Notes: positions are 16-bit counts kept by sensor pulses per axis
//
// Summary of operation
// - manual drive stops when limit switch opens
// - commands arrive as door unit messages
// - ignition off or manual leaves permit
// - registration presses within 50 ms both ignored
// - no registration above 3 km/h or off park
// - registration may be overwritten freely
// - memories volatile, cleared on power loss
// - no replay of unregistered slot
// - replay follows latest press, 50 ms cancels
// - interlocks forbid and abort replay
// - telescope starts 100 ms after tilt
// - one beep entering memory permit
// - two beeps on registration complete
// - one beep on replay start
// - ten beeps on sensor failure
// - under 4 pulses in 1 s is failure
// - error aborts replay, manual stays available
// - over 4 manual pulses clears automatic stop
`timescale 1ns/1ps
module steering_column_memory_ctrl
  import column_mem_pkg::*;
#(
  parameter int DISCRIM_CYCLES = DISCRIM_CYC,
  parameter int STAGGER_CYCLES = STAGGER_CYC,
  parameter int SENSE_CYCLES = SENSE_CYC,
  parameter int SPEED_CYCLES = SPEED_HOLD_CYC,
  parameter int BEEP_CYCLES = BEEP_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // vehicle inputs
  input wire logic ignition_in,
  input wire logic park_in,
  input wire logic [7:0] speed_kmh_in,
  input wire logic stop_sw_in,
  // manual switches: [1]=up/fwd [0]=down/back
  input wire logic [1:0] tilt_sw_in,
  input wire logic [1:0] tele_sw_in,
  // limit switches (high = closed) and sensor pulses
  input wire logic [1:0] tilt_limit_in,
  input wire logic [1:0] tele_limit_in,
  input wire logic tilt_pulse_in,
  input wire logic tele_pulse_in,
  // motor and buzzer drive
  output logic [1:0] tilt_motor_out,
  output logic [1:0] tele_motor_out,
  output logic buzzer_out,
  output logic irq_out
);
  // ==========================================================
  // bus slave
  logic ap_wr_reg, ap_rd_reg;
  logic [7:0] ap_addr_reg;
  wire ap_take = hsel_in && hready_in && htrans_in[1];
  wire wr_cmd = ap_wr_reg && (ap_addr_reg == CMD_OFS);
  wire wr_irq = ap_wr_reg && (ap_addr_reg == IRQ_OFS);
  wire wr_mask = ap_wr_reg && (ap_addr_reg == MASK_OFS);
  // commands from the door unit arrive as one-shot writes
  wire memsw_cmd = wr_cmd && hwdata_in[CMD_MEMSW];
  wire [1:0] pos_cmd = wr_cmd ? hwdata_in[CMD_POS1:CMD_POS0] : 2'h0;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ap_wr_reg <= 1'b0;
      ap_rd_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else begin
      ap_wr_reg <= ap_take && hwrite_in;
      ap_rd_reg <= ap_take && !hwrite_in;
      if (ap_take) begin
        ap_addr_reg <= haddr_in[7:0];
      end
    end
  end
  // ==========================================================
  // interlocks
  logic [31:0] spd_cnt_reg;
  wire over_speed = speed_kmh_in > SPEED_LIMIT_KMH;
  wire speed_long = spd_cnt_reg >= 32'(SPEED_CYCLES);
  wire manual_any = |tilt_sw_in || |tele_sw_in;
  wire reg_block = over_speed || !park_in;
  wire replay_block = !ignition_in || !park_in || speed_long || manual_any || stop_sw_in;
  // speed must persist before replay is aborted
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !over_speed) begin
      spd_cnt_reg <= 32'h0;
    end else if (!speed_long) begin
      spd_cnt_reg <= spd_cnt_reg + 32'h1;
    end
  end
  // ==========================================================
  // position switch discrimination window
  logic [31:0] win_cnt_reg;
  logic [1:0] win_sw_reg;
  logic win_clash_reg;
  wire win_open = win_sw_reg != 2'h0;
  wire win_end = win_open && (win_cnt_reg == 32'(DISCRIM_CYCLES - 1));
  wire clash_now = (pos_cmd == 2'h3) || (win_open && pos_cmd != 2'h0 && pos_cmd != win_sw_reg);
  wire pos_valid = win_end && !win_clash_reg && !clash_now;
  wire pos_slot = win_sw_reg[1];
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || win_end) begin
      win_cnt_reg <= 32'h0;
      win_sw_reg <= 2'h0;
      win_clash_reg <= 1'b0;
    end else if (win_open) begin
      win_cnt_reg <= win_cnt_reg + 32'h1;
      win_clash_reg <= win_clash_reg || clash_now;
    end else if (pos_cmd != 2'h0) begin
      win_sw_reg <= pos_cmd;
      win_clash_reg <= pos_cmd == 2'h3;
    end
  end
  // ==========================================================
  // position tracking from sensor pulses
  logic tilt_pulse_q_reg, tele_pulse_q_reg;
  logic [15:0] tilt_pos_reg, tele_pos_reg;
  wire tilt_edge = tilt_pulse_in && !tilt_pulse_q_reg;
  wire tele_edge = tele_pulse_in && !tele_pulse_q_reg;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      tilt_pulse_q_reg <= 1'b0;
      tele_pulse_q_reg <= 1'b0;
      tilt_pos_reg <= 16'h8000;
      tele_pos_reg <= 16'h8000;
    end else begin
      tilt_pulse_q_reg <= tilt_pulse_in;
      tele_pulse_q_reg <= tele_pulse_in;
      if (tilt_edge && tilt_motor_out[1]) tilt_pos_reg <= tilt_pos_reg + 16'h1;
      if (tilt_edge && tilt_motor_out[0]) tilt_pos_reg <= tilt_pos_reg - 16'h1;
      if (tele_edge && tele_motor_out[1]) tele_pos_reg <= tele_pos_reg + 16'h1;
      if (tele_edge && tele_motor_out[0]) tele_pos_reg <= tele_pos_reg - 16'h1;
    end
  end
  // ==========================================================
  // mode machine and memory slots (flip-flops, lost with power)
  mode_e mode_reg, mode_next;
  logic [15:0] slot_tilt_reg [2];
  logic [15:0] slot_tele_reg [2];
  logic [1:0] slot_valid_reg;
  logic tgt_slot_reg;
  logic auto_stop_reg;
  logic [31:0] stag_cnt_reg;
  wire tele_go = stag_cnt_reg >= 32'(STAGGER_CYCLES);
  wire [15:0] tgt_tilt = slot_tilt_reg[tgt_slot_reg];
  wire [15:0] tgt_tele = slot_tele_reg[tgt_slot_reg];
  wire tilt_at = tilt_pos_reg == tgt_tilt;
  wire tele_at = tele_pos_reg == tgt_tele;
  wire sensor_err;
  wire do_register = (mode_reg == ST_PERMIT) && pos_valid && !reg_block;
  wire do_replay = (mode_reg != ST_PERMIT) && pos_valid && slot_valid_reg[pos_slot] && !replay_block
                   && !auto_stop_reg;
  wire replay_done = (mode_reg == ST_REPLAY) && tilt_at && tele_at;
  wire replay_abort = (mode_reg == ST_REPLAY) && (replay_block || sensor_err);
  wire permit_enter = (mode_reg != ST_PERMIT) && memsw_cmd && ignition_in && !manual_any;
  // next mode selection
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      ST_IDLE: begin
        if (permit_enter) mode_next = ST_PERMIT;
        else if (do_replay) mode_next = ST_REPLAY;
      end
      ST_PERMIT: begin
        if (!ignition_in || manual_any) mode_next = ST_IDLE;
        else if (do_register) mode_next = ST_IDLE;
      end
      ST_REPLAY: begin
        if (replay_abort || replay_done) mode_next = ST_IDLE;
        else if (permit_enter) mode_next = ST_PERMIT;
      end
      default: mode_next = ST_IDLE;
    endcase
  end
  // mode, slots and stagger timer
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mode_reg <= ST_IDLE;
      slot_valid_reg <= 2'h0;
      slot_tilt_reg[0] <= 16'h0;
      slot_tilt_reg[1] <= 16'h0;
      slot_tele_reg[0] <= 16'h0;
      slot_tele_reg[1] <= 16'h0;
      tgt_slot_reg <= 1'b0;
      stag_cnt_reg <= 32'h0;
    end else begin
      mode_reg <= mode_next;
      if (do_register) begin
        slot_tilt_reg[pos_slot] <= tilt_pos_reg;
        slot_tele_reg[pos_slot] <= tele_pos_reg;
        slot_valid_reg[pos_slot] <= 1'b1;
      end
      if (do_replay) begin
        tgt_slot_reg <= pos_slot; // latest valid press retargets
        stag_cnt_reg <= 32'h0;
      end else if (mode_reg == ST_REPLAY && !tele_go) begin
        stag_cnt_reg <= stag_cnt_reg + 32'h1;
      end
    end
  end
  // ==========================================================
  // motor drive: manual has priority, limits cut drive
  wire replaying = mode_reg == ST_REPLAY;
  wire [1:0] tilt_auto = (replaying && !tilt_at) ? ((tilt_pos_reg < tgt_tilt) ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] tele_auto = (replaying && tele_go && !tele_at) ?
                         ((tele_pos_reg < tgt_tele) ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] tilt_want = manual_any ? (tilt_sw_in == 2'b11 ? 2'b00 : tilt_sw_in) : tilt_auto;
  wire [1:0] tele_want = manual_any ? (tele_sw_in == 2'b11 ? 2'b00 : tele_sw_in) : tele_auto;
  wire [1:0] tilt_drive = tilt_want & tilt_limit_in;
  wire [1:0] tele_drive = tele_want & tele_limit_in;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      tilt_motor_out <= 2'b00;
      tele_motor_out <= 2'b00;
    end else begin
      tilt_motor_out <= replay_abort ? 2'b00 : tilt_drive;
      tele_motor_out <= replay_abort ? 2'b00 : tele_drive;
    end
  end
  // ==========================================================
  // sensor supervision: count pulses for one second per run
  logic [31:0] sns_cnt_reg [2];
  logic [3:0] sns_pulses_reg [2];
  logic [1:0] err_flag_reg;
  wire [1:0] running = {|tele_motor_out, |tilt_motor_out};
  wire [1:0] edges = {tele_edge, tilt_edge};
  for (genvar a = 0; a < 2; a++) begin : g_axis
    wire win_done = running[a] && sns_cnt_reg[a] == 32'(SENSE_CYCLES - 1);
    wire few = sns_pulses_reg[a] < 4'(MIN_PULSES);
    always_ff @(posedge ref_clk_in) begin
      if (reset_in || !running[a]) begin
        sns_cnt_reg[a] <= 32'h0;
        sns_pulses_reg[a] <= 4'h0;
      end else if (!win_done) begin
        sns_cnt_reg[a] <= sns_cnt_reg[a] + 32'h1;
        if (edges[a] && sns_pulses_reg[a] != 4'hF) sns_pulses_reg[a] <= sns_pulses_reg[a] + 4'h1;
      end
    end
    // limit closed (still drivable) yet fewer than MIN_PULSES sensor pulses
    assign err_flag_reg[a] = win_done && few;
  end
  assign sensor_err = |err_flag_reg;
  wire tilt_good = running[0] && manual_any && sns_cnt_reg[0] == 32'(SENSE_CYCLES - 1)
                   && sns_pulses_reg[0] > 4'(MIN_PULSES);
  wire tele_good = running[1] && manual_any && sns_cnt_reg[1] == 32'(SENSE_CYCLES - 1)
                   && sns_pulses_reg[1] > 4'(MIN_PULSES);
  // automatic stop latch; manual drive never gated by it
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      auto_stop_reg <= 1'b0;
    end else if (sensor_err) begin
      auto_stop_reg <= 1'b1;
    end else if (tilt_good || tele_good) begin
      auto_stop_reg <= 1'b0;
    end
  end
  // ==========================================================
  // buzzer sequencer; beep length a parameter
  logic [3:0] beep_left_reg;
  logic [31:0] beep_cnt_reg;
  logic beep_on_reg;
  logic [3:0] beep_req;
  wire beep_tick = beep_cnt_reg == 32'(BEEP_CYCLES - 1);
  wire err_rise = sensor_err && !auto_stop_reg;
  // later events replace an unfinished pattern
  always_comb begin
    beep_req = 4'h0;
    if (err_rise) beep_req = BEEPS_ERROR;
    else if (do_register) beep_req = BEEPS_REG;
    else if (do_replay) beep_req = BEEPS_REPLAY;
    else if (permit_enter) beep_req = BEEPS_PERMIT;
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      beep_left_reg <= 4'h0;
      beep_cnt_reg <= 32'h0;
      beep_on_reg <= 1'b0;
    end else if (beep_req != 4'h0) begin
      beep_left_reg <= beep_req;
      beep_cnt_reg <= 32'h0;
      beep_on_reg <= 1'b1;
    end else if (beep_left_reg != 4'h0) begin
      beep_cnt_reg <= beep_tick ? 32'h0 : beep_cnt_reg + 32'h1;
      if (beep_tick) begin
        beep_on_reg <= !beep_on_reg && beep_left_reg != 4'h0; // count already dropped when the last beep ended
        if (beep_on_reg) beep_left_reg <= beep_left_reg - 4'h1;
      end
    end
  end
  assign buzzer_out = beep_on_reg;
  // ==========================================================
  // interrupts: sticky, write one to clear, set wins
  logic [IRQ_W-1:0] irq_reg, mask_reg;
  wire [IRQ_W-1:0] irq_set = {replay_abort, err_rise, replay_done, do_register};
  wire [IRQ_W-1:0] irq_clr = wr_irq ? hwdata_in[IRQ_W-1:0] : '0;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_reg <= '0;
      mask_reg <= '0;
    end else begin
      irq_reg <= (irq_reg & ~irq_clr) | irq_set;
      if (wr_mask) mask_reg <= hwdata_in[IRQ_W-1:0];
    end
  end
  assign irq_out = |(irq_reg & mask_reg);
  // ==========================================================
  // read mux, combinational in data phase
  wire [31:0] status_word = {24'h0, auto_stop_reg, slot_valid_reg, err_flag_reg, 1'b0, mode_reg};
  always_comb begin
    hrdata_out = 32'h0;
    if (ap_rd_reg) begin
      case (ap_addr_reg)
        STATUS_OFS: hrdata_out = status_word;
        IRQ_OFS: hrdata_out = {28'h0, irq_reg};
        MASK_OFS: hrdata_out = {28'h0, mask_reg};
        SLOT0_OFS: hrdata_out = {slot_tele_reg[0], slot_tilt_reg[0]};
        SLOT1_OFS: hrdata_out = {slot_tele_reg[1], slot_tilt_reg[1]};
        POS_OFS: hrdata_out = {tele_pos_reg, tilt_pos_reg};
        default: hrdata_out = 32'h0;
      endcase
    end
  end
endmodule : steering_column_memory_ctrl

// File: tb/column_mem_chk.sv
// Purpose: port assertions for the column memory controller
// Assumes: one clock domain, synchronous active high reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module column_mem_chk
  import column_mem_pkg::*;
#(parameter int BEEP_CYCLES = BEEP_CYC) (
  // clock, reset and bus
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // vehicle, switches and drives
  input wire logic ignition_in,
  input wire logic stop_sw_in,
  input wire logic [1:0] tilt_sw_in,
  input wire logic [1:0] tele_sw_in,
  input wire logic [1:0] tilt_limit_in,
  input wire logic [1:0] tele_limit_in,
  input wire logic [1:0] tilt_motor_out,
  input wire logic [1:0] tele_motor_out,
  input wire logic buzzer_out,
  input wire logic irq_out
);
  // ==========================================================
  // helpers: data phase tracking and buzzer run lengths
  logic dp_reg, dpr_reg;
  logic [7:0] dpa_reg, on_reg, off_reg;
  wire man_idle = (tilt_sw_in == 2'h0 || tilt_sw_in == 2'h3) && (tele_sw_in == 2'h0 || tele_sw_in == 2'h3);
  always_ff @(posedge ref_clk_in) begin
    dp_reg <= !reset_in && hsel_in && hready_in && htrans_in[1];
    dpa_reg <= haddr_in[7:0];
    dpr_reg <= !hwrite_in;
    on_reg <= (buzzer_out && !reset_in) ? on_reg + 8'h01 : 8'h00;
    off_reg <= (buzzer_out || reset_in) ? 8'h00 : ((off_reg == 8'hFF) ? off_reg : off_reg + 8'h01);
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  // ==========================================================
  // assertions
  property p_rst;
    disable iff (1'b0) reset_in |=> tilt_motor_out == 2'h0 && tele_motor_out == 2'h0 && !buzzer_out && !irq_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_bus;
    hreadyout_out && !hresp_out;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait or error response");
  property p_idle_rd;
    !dp_reg |-> hrdata_out == 32'h0;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside data phase");
  property p_cmd_rd;
    dp_reg && dpr_reg && (dpa_reg == CMD_OFS || dpa_reg == 8'h40) |-> hrdata_out == 32'h0;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command or unmapped read not zero");
  property p_tilt_lim;
    1'b1 |=> (tilt_motor_out & ~$past(tilt_limit_in)) == 2'h0;
  endproperty
  a_tilt_lim: assert property (p_tilt_lim) else $error("tilt drives past open limit");
  property p_tele_lim;
    1'b1 |=> (tele_motor_out & ~$past(tele_limit_in)) == 2'h0;
  endproperty
  a_tele_lim: assert property (p_tele_lim) else $error("telescope drives past open limit");
  property p_stop;
    stop_sw_in && man_idle |=> tilt_motor_out == 2'h0 && tele_motor_out == 2'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("motor runs with stop switch on");
  property p_ign;
    !ignition_in && man_idle |=> tilt_motor_out == 2'h0 && tele_motor_out == 2'h0;
  endproperty
  a_ign: assert property (p_ign) else $error("motor runs with ignition off");
  property p_beep_on;
    $fell(buzzer_out) |-> on_reg == 8'(BEEP_CYCLES);
  endproperty
  a_beep_on: assert property (p_beep_on) else $error("beep on time wrong");
  property p_beep_off;
    $rose(buzzer_out) |-> off_reg >= 8'(BEEP_CYCLES);
  endproperty
  a_beep_off: assert property (p_beep_off) else $error("beep gap too short");
endmodule : column_mem_chk
bind steering_column_memory_ctrl column_mem_chk #(.BEEP_CYCLES(BEEP_CYCLES)) u_chk (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .ignition_in(ignition_in), .stop_sw_in(stop_sw_in), .tilt_sw_in(tilt_sw_in),
  .tele_sw_in(tele_sw_in), .tilt_limit_in(tilt_limit_in), .tele_limit_in(tele_limit_in),
  .tilt_motor_out(tilt_motor_out), .tele_motor_out(tele_motor_out), .buzzer_out(buzzer_out), .irq_out(irq_out));

// File: tb/column_sensor_model.sv
// Purpose: position sensor stand-in for one column axis
// Assumes: one rising edge every two cycles while driven
// Notes: broken_in freezes the line like a cut harness
`timescale 1ns/1ps
module column_sensor_model (
  // clock and fault control
  input wire logic ref_clk_in,
  input wire logic broken_in,
  // motor drive and sensor line
  input wire logic [1:0] motor_in,
  output logic pulse_out
);
  // ==========================================================
  // toggle only while the motor turns; a stopped motor gives no pulses
  initial pulse_out = 1'b0;
  always @(posedge ref_clk_in) begin
    if ((motor_in == 2'h1 || motor_in == 2'h2) && !broken_in) begin
      pulse_out <= ~pulse_out;
    end
  end
endmodule : column_sensor_model

// File: tb/test_steering_column_memory_ctrl.sv
// Purpose: self-checking bench for the column memory controller
// Assumes: shortened counts, one sensor model per axis
// Notes: each scenario task judges its own outcome
`timescale 1ns/1ps
module test_steering_column_memory_ctrl;
  import column_mem_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, ign = 1'b1, park = 1'b1, stop = 1'b0, tbrk = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0, tsw = 2'h0, esw = 2'h0, tlim = 2'h3, elim = 2'h3;
  logic [2:0] hsize = 3'h2;
  logic [7:0] speed = 8'h00;
  logic tpul, epul, bz, bzq, irq, rdy, resp;
  logic [1:0] tmot, emot;
  logic [31:0] rdat;
  int error_cnt = 0, check_count = 0, beeps = 0;
  // ==========================================================
  // clock and instances
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  steering_column_memory_ctrl #(.DISCRIM_CYCLES(20), .STAGGER_CYCLES(10), .SENSE_CYCLES(50),
    .SPEED_CYCLES(20), .BEEP_CYCLES(4)) u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(rdat), .hreadyout_out(rdy), .hresp_out(resp),
    .ignition_in(ign), .park_in(park), .speed_kmh_in(speed), .stop_sw_in(stop), .tilt_sw_in(tsw),
    .tele_sw_in(esw), .tilt_limit_in(tlim), .tele_limit_in(elim), .tilt_pulse_in(tpul), .tele_pulse_in(epul),
    .tilt_motor_out(tmot), .tele_motor_out(emot), .buzzer_out(bz), .irq_out(irq));
  column_sensor_model u_tilt_sns (.ref_clk_in(ref_clk_in), .broken_in(tbrk), .motor_in(tmot), .pulse_out(tpul));
  column_sensor_model u_tele_sns (.ref_clk_in(ref_clk_in), .broken_in(1'b0), .motor_in(emot), .pulse_out(epul));
  // count buzzer onsets so patterns can be judged
  always @(posedge ref_clk_in) begin
    bzq <= bz;
    if (bz && !bzq) begin
      beeps <= beeps + 1;
    end
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : wt
  // one whole-word transfer; read data is stable over the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk_in); while (!rdy);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge ref_clk_in);
      q = rdat; // taken at the edge that closes the data phase
    end while (!rdy);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(STATUS_OFS, ALL, 32'h0);
    rd(POS_OFS, ALL, 32'h80008000);
    wr(8'h40, ALL);
    rd(8'h40, ALL, 32'h0);
    wr(MASK_OFS, 32'hF);
    rd(MASK_OFS, ALL, 32'hF);
  endtask : t_reset
  task automatic t_register();
    int b;
    b = beeps;
    wr(CMD_OFS, 32'h1);
    rd(STATUS_OFS, ALL, 32'h1);
    wt(40);
    chk(32'(beeps - b), 32'h1);
    wr(CMD_OFS, 32'h2);
    wr(CMD_OFS, 32'h4);
    wt(40);
    rd(STATUS_OFS, ALL, 32'h1);
    speed <= 8'h04;
    wr(CMD_OFS, 32'h4);
    wt(40);
    rd(STATUS_OFS, ALL, 32'h1);
    speed <= 8'h03;
    park <= 1'b0;
    wr(CMD_OFS, 32'h4);
    wt(40);
    rd(STATUS_OFS, ALL, 32'h1);
    park <= 1'b1;
    b = beeps;
    wr(CMD_OFS, 32'h2);
    wt(60);
    rd(STATUS_OFS, ALL, 32'h20);
    chk(32'(beeps - b), 32'h2);
    rd(SLOT0_OFS, ALL, 32'h80008000);
    chk({31'h0, irq}, 32'h1);
    wr(IRQ_OFS, 32'hF);
    wt(1);
    chk({31'h0, irq}, 32'h0);
    wr(CMD_OFS, 32'h1);
    ign <= 1'b0;
    wt(3);
    rd(STATUS_OFS, ALL, 32'h20);
    ign <= 1'b1;
    wt(40);
  endtask : t_register
  task automatic t_manual();
    tsw <= 2'h2;
    wt(10);
    chk({30'h0, tmot}, 32'h2);
    tlim <= 2'h1;
    wt(2);
    chk({30'h0, tmot}, 32'h0);
    tsw <= 2'h0;
    tlim <= 2'h3;
    esw <= 2'h2;
    wt(10);
    chk({30'h0, emot}, 32'h2);
    elim <= 2'h1;
    wt(2);
    chk({30'h0, emot}, 32'h0);
    esw <= 2'h0;
    elim <= 2'h3;
    wt(3);
  endtask : t_manual
  task automatic t_replay();
    int b, n;
    b = beeps;
    wr(CMD_OFS, 32'h2);
    for (n = 0; tmot == 2'h0 && n < 100; n++) wt(1);
    for (n = 0; emot == 2'h0 && n < 100; n++) wt(1);
    chk(32'(n >= 9 && n <= 11), 32'h1);
    for (n = 0; (tmot != 2'h0 || emot != 2'h0) && n < 3000; n++) wt(1);
    rd(POS_OFS, ALL, 32'h80008000);
    chk(32'(beeps - b), 32'h1);
    rd(IRQ_OFS, 32'h2, 32'h2);
    wr(IRQ_OFS, 32'hF);
  endtask : t_replay
  task automatic t_abort();
    tsw <= 2'h2;
    wt(30);
    tsw <= 2'h0;
    wt(3);
    wr(CMD_OFS, 32'h2);
    wt(25);
    chk({30'h0, tmot}, 32'h1);
    stop <= 1'b1;
    wt(2);
    chk({28'h0, tmot, emot}, 32'h0);
    rd(STATUS_OFS, 32'h3, 32'h0);
    rd(IRQ_OFS, 32'h8, 32'h8);
    stop <= 1'b0;
    wr(IRQ_OFS, 32'hF);
  endtask : t_abort
  task automatic t_sensor();
    int b;
    tbrk <= 1'b1;
    b = beeps;
    wr(CMD_OFS, 32'h2);
    wt(200);
    rd(STATUS_OFS, 32'h83, 32'h80);
    chk(32'(beeps - b), 32'h0B);
    rd(IRQ_OFS, 32'h4, 32'h4);
    tsw <= 2'h2;
    wt(3);
    chk({30'h0, tmot}, 32'h2);
    tbrk <= 1'b0;
    wt(60);
    tsw <= 2'h0;
    wt(3);
    rd(STATUS_OFS, 32'h80, 32'h0);
  endtask : t_sensor
  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    wt(2);
    reset_in <= 1'b0;
    t_reset();
    t_register();
    t_manual();
    t_replay();
    t_abort();
    t_sensor();
    report_and_stop();
  end
  initial begin
    wt(20000);
    error_cnt++;
    report_and_stop();
  end
endmodule : test_steering_column_memory_ctrl
